// File: rtl/radio_packet_buffer_filter.sv
// Packet buffer with host byte port on its own clock and receive frame filter
//
// Functional notes
// (R1) One 128-byte store, time-shared between transmit and receive frames.
// (R2) Host puts length byte at location 0, frame octets after it.
// (R3) Received frame length is kept in its own register, not the store.
// (R4) Link-quality byte is written at location frame length plus one.
// (R5) Unguarded reception overwrites whatever the store holds.
// (R6) While the overwrite guard is set, received data is not written.
// (R7) Guard never blocks host writes into the store.
// (R8) Each transferred byte advances the host location by one.
// (R9) The whole store can be moved in one uninterrupted host burst.
// (R10) Single-byte host transfers are supported as well.
// (R11) Host access stays available in the lowest-power state.
// (R12) Under-run errors are detected and reported as an interrupt.
// (R13) Promiscuous mode accepts every frame, skipping all checks.
// (R14) Beacon-only filtering rejects every non-beacon frame.
// (R15) Acknowledge requests built from frame control and sequence number.
// (R16) Message-pending bit of acknowledge set automatically for data polls; the code sets it for any command frame, and only while MSG_PENDING is high.
// (R17) Broadcast value matches both destination PAN and short address.
// (R18) Detailed failure status given for frames that fail checks.
// (R19) Under-run set when host reads a location not yet received.
`timescale 1ns/1ps
`include "rpbf_defs.svh"
module radio_packet_buffer_filter
	import rpbf_pkg::*;
#(
	parameter int DEPTH = `PB_DEPTH,
	parameter int AW = `PB_AW
) (
	// System clock and reset
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	// Host byte port, on the link clock
	input wire logic HOST_CLK,
	input wire logic HOST_START,
	input wire logic [AW-1:0] HOST_ADDR,
	input wire logic HOST_REQ,
	input wire logic HOST_WR,
	input wire logic [7:0] HOST_WDATA,
	output logic HOST_BUSY,
	output logic HOST_DONE,
	output logic [7:0] HOST_RDATA,
	// Receive datapath
	input wire logic RX_START,
	input wire logic [AW-1:0] RX_LEN,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_END,
	input wire logic [7:0] RX_LQI,
	// Configuration
	input wire logic RX_OVERWRITE_GUARD,
	input wire logic PROMISCUOUS,
	input wire logic BEACON_ONLY,
	input wire logic [15:0] OWN_PAN_ID,
	input wire logic [15:0] OWN_SHORT_ADDR,
	input wire logic [63:0] OWN_LONG_ADDR,
	input wire logic MSG_PENDING,
	input wire logic UNDERRUN_CLR,
	// Status
	output logic [AW-1:0] RX_FRAME_LEN,
	output logic RX_ACTIVE,
	output logic FRAME_DONE,
	output logic FRAME_ACCEPT,
	output logic [`FAIL_W-1:0] FILTER_FAIL,
	output logic ACK_REQ,
	output logic [7:0] ACK_SEQ,
	output logic ACK_FRAME_PENDING,
	output logic UNDERRUN_IRQ
);
	if (DEPTH != (1 << AW)) begin : g_chk
		$error("radio_packet_buffer_filter: DEPTH must equal 2**AW");
	end

	// Frame type, length and address checks; promiscuous mode bypasses every one of them
	function automatic logic [`FAIL_W-1:0] filter_eval(
		input logic [7:0] fc0,
		input logic [7:0] fc1,
		input logic [15:0] dpan,
		input logic [63:0] daddr,
		input logic [AW:0] seen,
		input logic promisc,
		input logic beacon_only,
		input logic [15:0] own_pan,
		input logic [15:0] own_short,
		input logic [63:0] own_long
	);
		logic [`FAIL_W-1:0] f;
		logic [1:0] dmode;
		logic [AW:0] need;
		f = '0;
		dmode = fc1[`FC1_DMODE_LSB +: 2];
		need = (dmode == `AM_NONE) ? (AW+1)'(`NEED_NONE) :
			(dmode == `AM_LONG) ? (AW+1)'(`NEED_LONG) : (AW+1)'(`NEED_SHORT);
		if (!promisc) begin // (R13)
			if (fc0[2:0] > `FT_LAST_VALID) begin
				f[`FAIL_TYPE] = 1'b1;
			end
			if (beacon_only && fc0[2:0] != `FT_BEACON) begin
				f[`FAIL_TYPE] = 1'b1; // (R14)
			end
			if (seen < need) begin
				f[`FAIL_SHORT] = 1'b1;
			end
			if (dmode != `AM_NONE && dpan != own_pan && dpan != `BCAST_16) begin
				f[`FAIL_PAN] = 1'b1; // (R17)
			end
			if (dmode == `AM_SHORT && daddr[15:0] != own_short && daddr[15:0] != `BCAST_16) begin
				f[`FAIL_ADDR] = 1'b1; // (R17)
			end
			if (dmode == `AM_LONG && daddr != own_long) begin
				f[`FAIL_ADDR] = 1'b1;
			end
		end
		return f;
	endfunction : filter_eval

	pb_mem_if #(.AW(AW), .DW(8)) mem ();

	pb_ram #(.DEPTH(DEPTH), .AW(AW), .DW(8)) u_ram (
		.clk(CLK_SYS),
		.mem(mem.store)
	); // (R1)

	// Host domain: reset synchroniser and request side of the handshake
	logic hrst_meta_r, hrst_r;
	logic [AW-1:0] h_ptr_r, h_ptr_nxt;
	logic [AW-1:0] h_addr_r, h_addr_nxt;
	logic h_wr_r, h_wr_nxt;
	logic [7:0] h_wdata_r, h_wdata_nxt;
	logic h_req_tog_r, h_req_tog_nxt;
	logic h_busy_r, h_busy_nxt;
	logic h_ack_s1_r, h_ack_s2_r, h_ack_seen_r;
	logic [7:0] h_rdata_r, h_rdata_nxt;
	logic h_done_r, h_done_nxt;
	logic h_ack_new;

	// System domain: host access side of the handshake
	logic s_req_s1_r, s_req_s2_r, s_req_seen_r;
	logic s_pend_r, s_pend_nxt;
	logic s_issue_r, s_issue_nxt;
	logic [7:0] s_rd_hold_r, s_rd_hold_nxt;
	logic s_ack_tog_r, s_ack_tog_nxt;
	logic underrun_r, underrun_nxt;
	logic s_go, s_req_new;

	// Receive side
	rx_state_t rx_state_r, rx_state_nxt;
	logic [AW:0] rx_idx_r, rx_idx_nxt;
	logic [AW-1:0] rx_len_r, rx_len_nxt;
	logic [7:0] fc0_r, fc0_nxt, fc1_r, fc1_nxt, seq_r, seq_nxt;
	logic [15:0] dpan_r, dpan_nxt;
	logic [63:0] daddr_r, daddr_nxt;
	logic done_r, done_nxt, accept_r, accept_nxt;
	logic [`FAIL_W-1:0] fail_r, fail_nxt, fail_now;
	logic ack_r, ack_nxt, ack_pend_r, ack_pend_nxt;
	logic [7:0] ack_seq_r, ack_seq_nxt;
	logic rx_wr, lqi_wr, rx_mem_use;

	// Host requests while busy are dropped; HOST_BUSY tells the host to wait
	assign h_ack_new = h_ack_s2_r ^ h_ack_seen_r;

	always_comb begin
		h_ptr_nxt = h_ptr_r;
		h_addr_nxt = h_addr_r;
		h_wr_nxt = h_wr_r;
		h_wdata_nxt = h_wdata_r;
		h_req_tog_nxt = h_req_tog_r;
		h_busy_nxt = h_busy_r;
		h_rdata_nxt = h_rdata_r;
		h_done_nxt = 1'b0;
		if (!h_busy_r && HOST_START) begin
			h_ptr_nxt = HOST_ADDR; // (R10)
		end
		if (!h_busy_r && HOST_REQ) begin
			h_addr_nxt = HOST_START ? HOST_ADDR : h_ptr_r;
			h_ptr_nxt = h_addr_nxt + AW'(1); // (R8)
			h_wr_nxt = HOST_WR;
			h_wdata_nxt = HOST_WDATA;
			h_req_tog_nxt = ~h_req_tog_r;
			h_busy_nxt = 1'b1;
		end
		if (h_busy_r && h_ack_new) begin
			h_rdata_nxt = s_rd_hold_r; // Held steady by the system side until next request
			h_busy_nxt = 1'b0;
			h_done_nxt = 1'b1;
		end
	end

	always_ff @(posedge HOST_CLK) begin
		hrst_meta_r <= SYS_RST;
		hrst_r <= hrst_meta_r;
		if (hrst_r) begin
			h_ptr_r <= '0;
			h_addr_r <= '0;
			h_wr_r <= 1'b0;
			h_wdata_r <= 8'h00;
			h_req_tog_r <= 1'b0;
			h_busy_r <= 1'b0;
			h_ack_s1_r <= 1'b0;
			h_ack_s2_r <= 1'b0;
			h_ack_seen_r <= 1'b0;
			h_rdata_r <= 8'h00;
			h_done_r <= 1'b0;
		end else begin
			h_ptr_r <= h_ptr_nxt;
			h_addr_r <= h_addr_nxt;
			h_wr_r <= h_wr_nxt;
			h_wdata_r <= h_wdata_nxt;
			h_req_tog_r <= h_req_tog_nxt;
			h_busy_r <= h_busy_nxt;
			h_ack_s1_r <= s_ack_tog_r;
			h_ack_s2_r <= h_ack_s1_r;
			h_ack_seen_r <= h_ack_s2_r;
			h_rdata_r <= h_rdata_nxt;
			h_done_r <= h_done_nxt;
		end
	end

	assign HOST_BUSY = h_busy_r;
	assign HOST_DONE = h_done_r;
	assign HOST_RDATA = h_rdata_r;

	// Receive writes win the store; a host byte waits for as long as receive writes keep the store busy
	assign rx_wr = (rx_state_r == RX_BODY) && RX_VALID && !RX_OVERWRITE_GUARD
		&& (rx_idx_r < {1'b0, rx_len_r}); // (R5) (R6)
	assign lqi_wr = (rx_state_r == RX_BODY) && RX_END && !RX_OVERWRITE_GUARD
		&& (rx_len_r != '1); // (R4) (R6)
	assign rx_mem_use = rx_wr || lqi_wr;
	assign s_req_new = s_req_s2_r ^ s_req_seen_r;
	// Power state is deliberately not an input: host access is gated only by receive writes
	assign s_go = s_pend_r && !rx_mem_use; // (R11) (R9)

	always_comb begin
		mem.en = 1'b0;
		mem.we = 1'b0;
		mem.addr = h_addr_r;
		mem.wdata = h_wdata_r;
		if (rx_wr) begin
			mem.en = 1'b1;
			mem.we = 1'b1;
			mem.addr = rx_idx_r[AW-1:0] + AW'(1);
			mem.wdata = RX_DATA;
		end else if (lqi_wr) begin
			mem.en = 1'b1;
			mem.we = 1'b1;
			mem.addr = rx_len_r + AW'(1); // (R4)
			mem.wdata = RX_LQI;
		end else if (s_go) begin
			mem.en = 1'b1;
			mem.we = h_wr_r; // (R7) (R2)
		end
	end

	always_comb begin
		s_pend_nxt = (s_pend_r || s_req_new) && !s_go;
		s_issue_nxt = s_go;
		s_rd_hold_nxt = s_rd_hold_r;
		s_ack_tog_nxt = s_ack_tog_r;
		if (s_issue_r) begin
			s_rd_hold_nxt = mem.rdata;
			s_ack_tog_nxt = ~s_ack_tog_r;
		end
		underrun_nxt = underrun_r && !UNDERRUN_CLR;
		if (s_go && !h_wr_r && rx_state_r == RX_BODY && !RX_OVERWRITE_GUARD
			&& {1'b0, h_addr_r} > rx_idx_r) begin
			underrun_nxt = 1'b1; // (R19) (R12)
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			s_req_s1_r <= 1'b0;
			s_req_s2_r <= 1'b0;
			s_req_seen_r <= 1'b0;
			s_pend_r <= 1'b0;
			s_issue_r <= 1'b0;
			s_rd_hold_r <= 8'h00;
			s_ack_tog_r <= 1'b0;
			underrun_r <= 1'b0;
		end else begin
			s_req_s1_r <= h_req_tog_r;
			s_req_s2_r <= s_req_s1_r;
			s_req_seen_r <= s_req_s2_r;
			s_pend_r <= s_pend_nxt;
			s_issue_r <= s_issue_nxt;
			s_rd_hold_r <= s_rd_hold_nxt;
			s_ack_tog_r <= s_ack_tog_nxt;
			underrun_r <= underrun_nxt;
		end
	end

	assign UNDERRUN_IRQ = underrun_r; // (R12)

	// Frame parsing; fields are captured even under guard so filtering still works
	assign fail_now = filter_eval(fc0_r, fc1_r, dpan_r, daddr_r, rx_idx_r, PROMISCUOUS,
		BEACON_ONLY, OWN_PAN_ID, OWN_SHORT_ADDR, OWN_LONG_ADDR);

	always_comb begin
		rx_state_nxt = rx_state_r;
		rx_idx_nxt = rx_idx_r;
		rx_len_nxt = rx_len_r;
		fc0_nxt = fc0_r;
		fc1_nxt = fc1_r;
		seq_nxt = seq_r;
		dpan_nxt = dpan_r;
		daddr_nxt = daddr_r;
		done_nxt = 1'b0;
		accept_nxt = accept_r;
		fail_nxt = fail_r;
		ack_nxt = 1'b0;
		ack_seq_nxt = ack_seq_r;
		ack_pend_nxt = ack_pend_r;
		case (rx_state_r)
			RX_IDLE: begin
				if (RX_START) begin
					rx_len_nxt = RX_LEN; // (R3)
					rx_idx_nxt = '0;
					fc0_nxt = 8'h00;
					fc1_nxt = 8'h00;
					dpan_nxt = 16'h0000;
					daddr_nxt = 64'h0000_0000_0000_0000;
					rx_state_nxt = RX_BODY;
				end
			end
			RX_BODY: begin
				if (RX_VALID && rx_idx_r < {1'b0, rx_len_r}) begin
					rx_idx_nxt = rx_idx_r + (AW+1)'(1);
					if (rx_idx_r == (AW+1)'(`OFS_FC0)) fc0_nxt = RX_DATA;
					if (rx_idx_r == (AW+1)'(`OFS_FC1)) fc1_nxt = RX_DATA;
					if (rx_idx_r == (AW+1)'(`OFS_SEQ)) seq_nxt = RX_DATA;
					for (int j = 0; j < 2; j++) begin
						if (rx_idx_r == (AW+1)'(`OFS_DPAN + j)) dpan_nxt[j*8 +: 8] = RX_DATA;
					end
					for (int j = 0; j < 8; j++) begin
						if (rx_idx_r == (AW+1)'(`OFS_DADDR + j)) daddr_nxt[j*8 +: 8] = RX_DATA;
					end
				end
				if (RX_END) begin
					done_nxt = 1'b1;
					fail_nxt = fail_now; // (R18)
					accept_nxt = (fail_now == '0);
					if (fail_now == '0 && fc0_r[`FC0_ACKREQ_BIT]
						&& !(fc1_r[`FC1_DMODE_LSB +: 2] == `AM_SHORT && daddr_r[15:0] == `BCAST_16)) begin
						ack_nxt = 1'b1; // (R15)
						ack_seq_nxt = seq_r; // (R15)
						ack_pend_nxt = (fc0_r[2:0] == `FT_CMD) && MSG_PENDING; // (R16)
					end
					rx_state_nxt = RX_IDLE;
				end
			end
			default: begin
				rx_state_nxt = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			rx_state_r <= RX_IDLE;
			rx_idx_r <= '0;
			rx_len_r <= '0;
			fc0_r <= 8'h00;
			fc1_r <= 8'h00;
			seq_r <= 8'h00;
			dpan_r <= 16'h0000;
			daddr_r <= 64'h0000_0000_0000_0000;
			done_r <= 1'b0;
			accept_r <= 1'b0;
			fail_r <= '0;
			ack_r <= 1'b0;
			ack_seq_r <= 8'h00;
			ack_pend_r <= 1'b0;
		end else begin
			rx_state_r <= rx_state_nxt;
			rx_idx_r <= rx_idx_nxt;
			rx_len_r <= rx_len_nxt;
			fc0_r <= fc0_nxt;
			fc1_r <= fc1_nxt;
			seq_r <= seq_nxt;
			dpan_r <= dpan_nxt;
			daddr_r <= daddr_nxt;
			done_r <= done_nxt;
			accept_r <= accept_nxt;
			fail_r <= fail_nxt;
			ack_r <= ack_nxt;
			ack_seq_r <= ack_seq_nxt;
			ack_pend_r <= ack_pend_nxt;
		end
	end

	assign RX_FRAME_LEN = rx_len_r;
	assign RX_ACTIVE = (rx_state_r == RX_BODY);
	assign FRAME_DONE = done_r;
	assign FRAME_ACCEPT = accept_r;
	assign FILTER_FAIL = fail_r;
	assign ACK_REQ = ack_r;
	assign ACK_SEQ = ack_seq_r;
	assign ACK_FRAME_PENDING = ack_pend_r;
endmodule : radio_packet_buffer_filter

// File: inc/rpbf_defs.svh
// Constants for the radio packet buffer and receive filter
`ifndef RPBF_DEFS_SVH
`define RPBF_DEFS_SVH
`define PB_DEPTH 128
`define PB_AW 7
`define FT_BEACON 3'h0
`define FT_CMD 3'h3
`define FT_LAST_VALID 3'h3
`define FC0_ACKREQ_BIT 5
`define FC1_DMODE_LSB 2
`define AM_NONE 2'h0
`define AM_SHORT 2'h2
`define AM_LONG 2'h3
`define BCAST_16 16'hFFFF
`define OFS_FC0 0
`define OFS_FC1 1
`define OFS_SEQ 2
`define OFS_DPAN 3
`define OFS_DADDR 5
`define NEED_NONE 3
`define NEED_SHORT 7
`define NEED_LONG 13
`define FAIL_W 4
`define FAIL_TYPE 0
`define FAIL_PAN 1
`define FAIL_ADDR 2
`define FAIL_SHORT 3
`endif

// File: inc/rpbf_pkg.sv
// Types shared by the packet buffer design
package rpbf_pkg;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_BODY = 2'b01
	} rx_state_t;
	typedef logic [7:0] pb_byte_t;
endpackage : rpbf_pkg

// File: inc/pb_mem_if.sv
// Carrier between the buffer controller and the buffer storage
`timescale 1ns/1ps
interface pb_mem_if #(parameter int AW = 7, parameter int DW = 8);
	logic en;
	logic we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport owner (output en, output we, output addr, output wdata, input rdata);
	modport store (input en, input we, input addr, input wdata, output rdata);
endinterface : pb_mem_if

// File: rtl/pb_ram.sv
// Single-port byte storage with registered read data
`timescale 1ns/1ps
module pb_ram #(
	parameter int DEPTH = 128,
	parameter int AW = 7,
	parameter int DW = 8
) (
	// Clock
	input wire logic clk,
	// Access port
	pb_mem_if.store mem
);
	logic [DW-1:0] store_r [DEPTH];
	logic [DW-1:0] rdata_r;

	if (DEPTH > (1 << AW)) begin : g_chk
		$error("pb_ram: DEPTH exceeds address range");
	end

	always_ff @(posedge clk) begin
		if (mem.en && mem.we) begin
			store_r[mem.addr] <= mem.wdata;
		end
		if (mem.en) begin
			rdata_r <= store_r[mem.addr];
		end
	end

	assign mem.rdata = rdata_r;
endmodule : pb_ram

// File: tb/rpbf_properties.sv
// Concurrent checks on the packet buffer top ports
`timescale 1ns/1ps
`include "rpbf_defs.svh"
module rpbf_properties #(
	parameter int AW = 7
) (
	// Clocks and reset
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic HOST_CLK,
	// Host port
	input wire logic HOST_REQ,
	input wire logic HOST_BUSY,
	input wire logic HOST_DONE,
	// Receive side
	input wire logic RX_START,
	input wire logic [AW-1:0] RX_LEN,
	input wire logic RX_END,
	input wire logic PROMISCUOUS,
	input wire logic UNDERRUN_CLR,
	// Status
	input wire logic [AW-1:0] RX_FRAME_LEN,
	input wire logic RX_ACTIVE,
	input wire logic FRAME_DONE,
	input wire logic FRAME_ACCEPT,
	input wire logic [`FAIL_W-1:0] FILTER_FAIL,
	input wire logic ACK_REQ,
	input wire logic UNDERRUN_IRQ
);
	property p_len;
		@(posedge CLK_SYS) disable iff (SYS_RST) RX_START && !RX_ACTIVE |=> RX_ACTIVE && RX_FRAME_LEN == $past(RX_LEN);
	endproperty
	a_len: assert property (p_len) else $error("frame length not held");
	property p_done;
		@(posedge CLK_SYS) disable iff (SYS_RST) RX_END && RX_ACTIVE |=> FRAME_DONE && !RX_ACTIVE ##1 !FRAME_DONE;
	endproperty
	a_done: assert property (p_done) else $error("frame end not reported");
	property p_ack;
		@(posedge CLK_SYS) disable iff (SYS_RST) ACK_REQ |-> FRAME_DONE && FRAME_ACCEPT;
	endproperty
	a_ack: assert property (p_ack) else $error("ack for a frame not accepted");
	property p_prom;
		@(posedge CLK_SYS) disable iff (SYS_RST) FRAME_DONE && $past(PROMISCUOUS) |-> FRAME_ACCEPT;
	endproperty
	a_prom: assert property (p_prom) else $error("frame refused in promiscuous mode");
	property p_fail;
		@(posedge CLK_SYS) disable iff (SYS_RST) FRAME_DONE && !$past(PROMISCUOUS) |-> FRAME_ACCEPT == (FILTER_FAIL == '0);
	endproperty
	a_fail: assert property (p_fail) else $error("fail status disagrees with verdict");
	property p_sticky;
		@(posedge CLK_SYS) disable iff (SYS_RST) UNDERRUN_IRQ && !UNDERRUN_CLR |=> UNDERRUN_IRQ;
	endproperty
	a_sticky: assert property (p_sticky) else $error("under-run flag lost");
	property p_urun_idle;
		@(posedge CLK_SYS) disable iff (SYS_RST) !RX_ACTIVE && !UNDERRUN_IRQ |=> !UNDERRUN_IRQ;
	endproperty
	a_urun_idle: assert property (p_urun_idle) else $error("under-run outside a frame");
	property p_hreq;
		@(posedge HOST_CLK) disable iff (SYS_RST) HOST_REQ && !HOST_BUSY |=> HOST_BUSY ##[1:12] HOST_DONE;
	endproperty
	a_hreq: assert property (p_hreq) else $error("host byte not finished");
	property p_hdone;
		@(posedge HOST_CLK) disable iff (SYS_RST) HOST_DONE |-> !HOST_BUSY ##1 !HOST_DONE;
	endproperty
	a_hdone: assert property (p_hdone) else $error("host done not a single pulse");
	c_acc: cover property (@(posedge CLK_SYS) FRAME_DONE && FRAME_ACCEPT);
	c_rej: cover property (@(posedge CLK_SYS) FRAME_DONE && !FRAME_ACCEPT);
	c_urun: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) $rose(UNDERRUN_IRQ));
	c_host: cover property (@(posedge HOST_CLK) HOST_DONE);
endmodule : rpbf_properties
bind radio_packet_buffer_filter rpbf_properties #(.AW(AW)) i_props (
	.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .HOST_CLK(HOST_CLK), .HOST_REQ(HOST_REQ),
	.HOST_BUSY(HOST_BUSY), .HOST_DONE(HOST_DONE), .RX_START(RX_START), .RX_LEN(RX_LEN),
	.RX_END(RX_END), .PROMISCUOUS(PROMISCUOUS), .UNDERRUN_CLR(UNDERRUN_CLR),
	.RX_FRAME_LEN(RX_FRAME_LEN), .RX_ACTIVE(RX_ACTIVE), .FRAME_DONE(FRAME_DONE),
	.FRAME_ACCEPT(FRAME_ACCEPT), .FILTER_FAIL(FILTER_FAIL), .ACK_REQ(ACK_REQ), .UNDERRUN_IRQ(UNDERRUN_IRQ));

// File: tb/rpbf_host_model.sv
// Host side model driving the byte port on the link clock
`timescale 1ns/1ps
module rpbf_host_model (
	// Link clock
	input wire logic HOST_CLK,
	// Request
	output logic HOST_START,
	output logic [6:0] HOST_ADDR,
	output logic HOST_REQ,
	output logic HOST_WR,
	output logic [7:0] HOST_WDATA,
	// Answer
	input wire logic HOST_BUSY,
	input wire logic HOST_DONE,
	input wire logic [7:0] HOST_RDATA
);
	int hangs = 0;
	initial begin
		{HOST_START, HOST_ADDR, HOST_REQ, HOST_WR, HOST_WDATA} = '0;
	end
	// Address, direction and data lines go to inverted values once released, start and request go low, so stale data never looks valid
	task automatic xfer(input logic st, input logic [6:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge HOST_CLK) #1;
		{HOST_START, HOST_ADDR, HOST_REQ, HOST_WR, HOST_WDATA} = {st, a, 1'b1, w, d};
		@(posedge HOST_CLK) #1;
		{HOST_START, HOST_ADDR, HOST_REQ, HOST_WR, HOST_WDATA} = {1'b0, ~a, 1'b0, ~w, ~d};
		n = 0;
		while (HOST_DONE !== 1'b1 && n < 30) begin
			@(posedge HOST_CLK) #1;
			n++;
		end
		if (n == 30)
			hangs++;
		q = HOST_RDATA;
	endtask : xfer
endmodule : rpbf_host_model

// File: tb/radio_packet_buffer_filter_bench.sv
// Self-checking bench for the packet buffer and receive filter
`timescale 1ns/1ps
module radio_packet_buffer_filter_bench;
	import rpbf_pkg::*;
	localparam logic [15:0] PAN = 16'h1A2B;
	localparam logic [15:0] ADR = 16'h0C0D;
	localparam logic [63:0] LADR = 64'h0123_4567_89AB_CDEF;
	logic clk_sys, host_clk, h_start, h_req, h_wr, h_busy, h_done;
	logic [6:0] h_addr, rx_len = '0, frame_len;
	logic [7:0] h_wdata, h_rdata, ack_seq, q;
	logic sys_rst = 1'b1, rx_start = 1'b0, rx_valid = 1'b0, rx_end = 1'b0, guard = 1'b0;
	logic promisc = 1'b0, beacon_only = 1'b0, msg_pend = 1'b0, urun_clr = 1'b0;
	logic [7:0] rx_data = '0, rx_lqi = '0, sq = 8'h40;
	logic rx_active, frame_done, frame_accept, ack_req, ack_fp, urun_irq;
	logic [3:0] filter_fail;
	logic [7:0] fr [0:10];
	int failures = 0;
	int tests_run = 0;
	radio_packet_buffer_filter i_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .HOST_CLK(host_clk),
		.HOST_START(h_start), .HOST_ADDR(h_addr), .HOST_REQ(h_req), .HOST_WR(h_wr), .HOST_WDATA(h_wdata),
		.HOST_BUSY(h_busy), .HOST_DONE(h_done), .HOST_RDATA(h_rdata), .RX_START(rx_start), .RX_LEN(rx_len),
		.RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_END(rx_end), .RX_LQI(rx_lqi), .RX_OVERWRITE_GUARD(guard),
		.PROMISCUOUS(promisc), .BEACON_ONLY(beacon_only), .OWN_PAN_ID(PAN), .OWN_SHORT_ADDR(ADR),
		.OWN_LONG_ADDR(LADR), .MSG_PENDING(msg_pend), .UNDERRUN_CLR(urun_clr),
		.RX_FRAME_LEN(frame_len), .RX_ACTIVE(rx_active), .FRAME_DONE(frame_done), .FRAME_ACCEPT(frame_accept),
		.FILTER_FAIL(filter_fail), .ACK_REQ(ack_req), .ACK_SEQ(ack_seq), .ACK_FRAME_PENDING(ack_fp),
		.UNDERRUN_IRQ(urun_irq));
	rpbf_host_model i_host (.HOST_CLK(host_clk), .HOST_START(h_start), .HOST_ADDR(h_addr), .HOST_REQ(h_req),
		.HOST_WR(h_wr), .HOST_WDATA(h_wdata), .HOST_BUSY(h_busy), .HOST_DONE(h_done), .HOST_RDATA(h_rdata));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		host_clk = 1'b0;
		#7;
		forever #24 host_clk = ~host_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] pat(input int i);
		return 8'(i * 7 + 90);
	endfunction : pat
	task automatic rd(input int a, input logic [7:0] exp);
		i_host.xfer(1'b1, 7'(a), 1'b0, 8'h00, q);
		chk(q, exp);
	endtask : rd
	task automatic sys_tick();
		@(posedge clk_sys) #1;
	endtask : sys_tick
	task automatic send(input logic [7:0] f0, input logic [15:0] pan, adr, input logic acc);
		fr = '{f0, 8'h08, sq, pan[7:0], pan[15:8], adr[7:0], adr[15:8], 8'h11, 8'h22, 8'h33, 8'hC7};
		sys_tick();
		rx_start = 1'b1;
		rx_len = 7'd10;
		sys_tick();
		rx_start = 1'b0;
		for (int i = 0; i < 10; i++) begin
			rx_valid = 1'b1;
			rx_data = fr[i];
			sys_tick();
		end
		rx_valid = 1'b0;
		rx_end = 1'b1;
		rx_lqi = fr[10];
		sys_tick();
		rx_end = 1'b0;
		chk({7'h0, frame_done}, 8'h01);
		chk({7'h0, frame_accept}, {7'h0, acc});
		chk({1'b0, frame_len}, 8'h0A);
		sq++;
	endtask : send
	task automatic flt(input logic [7:0] f0, input logic [15:0] pan, adr, input logic pr, bo, acc, input logic [3:0] fl);
		promisc = pr;
		beacon_only = bo;
		send(f0, pan, adr, acc);
		if (!pr)
			chk({4'h0, filter_fail}, {4'h0, fl});
	endtask : flt
	task automatic t_burst();
		for (int i = 0; i < 128; i++)
			i_host.xfer(i == 0, 7'h00, 1'b1, pat(i), q);
		for (int i = 0; i < 128; i++) begin
			i_host.xfer(i == 0, 7'h00, 1'b0, 8'h00, q);
			chk(q, pat(i));
		end
	endtask : t_burst
	task automatic t_guard();
		guard = 1'b1;
		i_host.xfer(1'b1, 7'd50, 1'b1, 8'hC3, q);
		rd(50, 8'hC3);
		rd(49, pat(49));
		send(8'h01, PAN, ADR, 1'b1);
		for (int i = 1; i < 12; i++)
			rd(i, pat(i));
		guard = 1'b0;
	endtask : t_guard
	task automatic t_rx();
		send(8'h21, PAN, ADR, 1'b1);
		chk({7'h0, ack_req}, 8'h01);
		chk(ack_seq, fr[2]);
		for (int i = 1; i < 11; i++)
			rd(i, fr[i-1]);
		rd(11, fr[10]);
		rd(0, pat(0));
	endtask : t_rx
	task automatic t_filter();
		flt(8'h01, 16'h7777, ADR, 1'b0, 1'b0, 1'b0, 4'h2);
		flt(8'h01, 16'h7777, 16'h7777, 1'b1, 1'b0, 1'b1, 4'h0);
		flt(8'h01, PAN, 16'h5555, 1'b0, 1'b0, 1'b0, 4'h4);
		flt(8'h01, PAN, ADR, 1'b0, 1'b1, 1'b0, 4'h1);
		flt(8'h00, PAN, ADR, 1'b0, 1'b1, 1'b1, 4'h0);
		flt(8'h01, 16'hFFFF, 16'hFFFF, 1'b0, 1'b0, 1'b1, 4'h0);
		msg_pend = 1'b1;
		flt(8'h23, PAN, ADR, 1'b0, 1'b0, 1'b1, 4'h0);
		chk({7'h0, ack_fp}, 8'h01);
		flt(8'h21, PAN, ADR, 1'b0, 1'b0, 1'b1, 4'h0);
		chk({7'h0, ack_fp}, 8'h00);
		msg_pend = 1'b0;
	endtask : t_filter
	// Long destination address: fourteen bytes so the length check passes
	task automatic t_long(input logic [63:0] la, input logic acc, input logic [3:0] fl);
		logic [7:0] lf [0:13];
		lf = '{8'h21, 8'h0C, sq, PAN[7:0], PAN[15:8], la[7:0], la[15:8], la[23:16], la[31:24],
			la[39:32], la[47:40], la[55:48], la[63:56], 8'h5A};
		sys_tick();
		rx_start = 1'b1;
		rx_len = 7'd14;
		sys_tick();
		rx_start = 1'b0;
		for (int i = 0; i < 14; i++) begin
			rx_valid = 1'b1;
			rx_data = lf[i];
			sys_tick();
		end
		rx_valid = 1'b0;
		rx_end = 1'b1;
		sys_tick();
		rx_end = 1'b0;
		chk({7'h0, frame_accept}, {7'h0, acc});
		chk({4'h0, filter_fail}, {4'h0, fl});
		chk({7'h0, ack_req}, {7'h0, acc});
		sq++;
	endtask : t_long
	task automatic t_underrun();
		sys_tick();
		rx_start = 1'b1;
		rx_len = 7'd20;
		sys_tick();
		rx_start = 1'b0;
		rx_valid = 1'b1;
		rx_data = 8'h99;
		sys_tick();
		rx_valid = 1'b0;
		chk({7'h0, urun_irq}, 8'h00);
		i_host.xfer(1'b1, 7'd100, 1'b0, 8'h00, q);
		sys_tick();
		chk({7'h0, urun_irq}, 8'h01);
		rx_end = 1'b1;
		sys_tick();
		rx_end = 1'b0;
		chk({4'h0, filter_fail}, 8'h08);
		urun_clr = 1'b1;
		sys_tick();
		urun_clr = 1'b0;
		sys_tick();
		chk({7'h0, urun_irq}, 8'h00);
	endtask : t_underrun
	task automatic give_verdict();
		failures += i_host.hangs;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	initial begin
		#1_000_000;
		failures++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		repeat (4) @(posedge host_clk);
		t_burst();
		t_guard();
		t_rx();
		t_filter();
		t_long(LADR, 1'b1, 4'h0);
		t_long(LADR ^ 64'h0000_0000_0000_0001, 1'b0, 4'h4);
		t_underrun();
		give_verdict();
	end
endmodule : radio_packet_buffer_filter_bench
